// [peripheral_pin_function_select.sv]
// Shared pin function multiplexer for serial receive, two-wire, programmer, timer and buzzer.
// Assumes pins arrive unsynchronised and configuration ports come from registers on clk.

`timescale 1ns/1ns

module peripheral_pin_function_select import pin_mux_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Pads
   input wire logic [N_PINS-1:0] pad_in,
   output pad_drive_t pads_q,
   // Configuration
   input port_cfg_t port_cfg,
   input periph_cfg_t periph_cfg,
   // Peripheral side
   input periph_out_t periph_out,
   output periph_in_t periph_in_q,
   output logic [N_PINS-1:0] gpio_in_q
);

   // ==========================================================
   // Input synchronisers
   logic [N_PINS-1:0] sync1_q, sync2_q, sync3_q, stable_q, stable_d;

   assign stable_d = (sync2_q & sync3_q) | (stable_q & (sync2_q ^ sync3_q));

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_q <= PIN_RESET;
         sync2_q <= PIN_RESET;
         sync3_q <= PIN_RESET;
         stable_q <= PIN_RESET;
      end else begin
         sync1_q <= pad_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         stable_q <= stable_d;
      end
   end

   // ==========================================================
   // Buzzer divider
   logic [15:0] buzz_cnt_q, buzz_cnt_d, buzz_limit;
   logic buzz_q, buzz_d, buzz_tick;

   assign buzz_limit = BUZZ_DIV_BASE >> periph_cfg.buzz_freq_sel;
   assign buzz_tick = periph_cfg.buzz_en && (buzz_cnt_q >= buzz_limit);
   assign buzz_cnt_d = (!periph_cfg.buzz_en || buzz_tick) ? BUZZ_CNT_RESET
                       : 16'(buzz_cnt_q + 16'h0001);
   assign buzz_d = !periph_cfg.buzz_en ? 1'b0 : (buzz_tick ? !buzz_q : buzz_q);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         buzz_cnt_q <= BUZZ_CNT_RESET;
         buzz_q <= 1'b0;
      end else begin
         buzz_cnt_q <= buzz_cnt_d;
         buzz_q <= buzz_d;
      end
   end

   // ==========================================================
   // Peripheral claims on pins
   logic [N_PINS-1:0] dir, omd;
   logic [N_PINS-1:0] fn_drive, fn_oe, fn_val;
   logic tw_data_a, tw_data_b, tw_clock_a, tw_clock_b, tw_base, buzz_on;

   assign dir = port_cfg.port_direction;
   assign omd = port_cfg.output_function_select;

   // Receive pins are inputs only; they never claim the driver.
   assign fn_drive[UART2_RX_PIN_A:UART0_RX_PIN_A] = 5'h00;
   assign fn_oe[UART2_RX_PIN_A:UART0_RX_PIN_A] = 5'h00;
   assign fn_val[UART2_RX_PIN_A:UART0_RX_PIN_A] = 5'h00;

   // Two-wire pins drive open-drain only.
   assign tw_base = periph_cfg.twowire_en;
   assign tw_data_a = tw_base && !periph_cfg.twowire_sel_b
                      && dir[TWOWIRE_DATA_PIN_A] && port_cfg.opendrain_control[TWOWIRE_DATA_PIN_A];
   assign tw_data_b = tw_base && periph_cfg.twowire_sel_b
                      && dir[TWOWIRE_DATA_PIN_B] && port_cfg.opendrain_control[TWOWIRE_DATA_PIN_B];
   assign tw_clock_a = tw_base && !periph_cfg.twowire_sel_b
                       && dir[TWOWIRE_CLOCK_PIN_A]
                       && port_cfg.opendrain_control[TWOWIRE_CLOCK_PIN_A];
   assign tw_clock_b = tw_base && periph_cfg.twowire_sel_b
                       && dir[TWOWIRE_CLOCK_PIN_B]
                       && port_cfg.opendrain_control[TWOWIRE_CLOCK_PIN_B];
   assign fn_drive[TWOWIRE_CLOCK_PIN_B:TWOWIRE_DATA_PIN_A] =
      {tw_clock_b, tw_clock_a, tw_data_b, tw_data_a};
   assign fn_oe[TWOWIRE_CLOCK_PIN_B:TWOWIRE_DATA_PIN_A] = 4'hf;
   assign fn_val[TWOWIRE_CLOCK_PIN_B:TWOWIRE_DATA_PIN_A] =
      {{2{periph_out.twowire_clock_out}}, {2{periph_out.twowire_data_out}}};

   // Programmer data is bidirectional, its clock is forced to input.
   assign fn_drive[PROGRAMMER_CLOCK_PIN:PROGRAMMER_DATA_PIN] = {2{periph_cfg.programmer_en}};
   assign fn_oe[PROGRAMMER_CLOCK_PIN:PROGRAMMER_DATA_PIN] =
      {1'b0, periph_out.programmer_data_oe};
   assign fn_val[PROGRAMMER_CLOCK_PIN:PROGRAMMER_DATA_PIN] =
      {1'b0, periph_out.programmer_data_out};

   // Timer pins, two per timer.
   logic [N_TIMERS-1:0] ev_q_d;
   genvar t;
   generate
      for (t = 0; t < N_TIMERS; t++) begin : g_timer
         localparam int PA = TIMER0_IO_PIN_A + 2 * t;
         localparam int PB = PA + 1;
         assign fn_drive[PA] = omd[PA] && dir[PA];
         assign fn_drive[PB] = omd[PB] && dir[PB];
         assign fn_oe[PB:PA] = 2'h3;
         assign fn_val[PB:PA] = {2{periph_out.timer_out[t]}};
         assign ev_q_d[t] = periph_cfg.timer_ev_route[t] && (periph_cfg.timer_ev_sel_b[t]
                            ? (!dir[PB] && stable_q[PB])
                            : (!dir[PA] && stable_q[PA]));
      end
   endgenerate

   // Buzzer pair drives a differential signal.
   assign buzz_on = periph_cfg.buzz_en;
   assign fn_drive[BUZZER_DRIVE_PIN] = buzz_on && omd[BUZZER_DRIVE_PIN]
                                       && dir[BUZZER_DRIVE_PIN];
   assign fn_drive[BUZZER_DRIVE_INVERTED_PIN] = buzz_on && omd[BUZZER_DRIVE_INVERTED_PIN]
                                                && dir[BUZZER_DRIVE_INVERTED_PIN];
   assign fn_oe[BUZZER_DRIVE_INVERTED_PIN:BUZZER_DRIVE_PIN] = 2'h3;
   assign fn_val[BUZZER_DRIVE_INVERTED_PIN:BUZZER_DRIVE_PIN] = {!buzz_q, buzz_q};

   // ==========================================================
   // Pad drive
   logic [N_PINS-1:0] drv_req, drv_val;
   pad_drive_t pads_d;

   assign drv_req = (fn_drive & fn_oe) | (~fn_drive & dir);
   assign drv_val = (fn_drive & fn_val) | (~fn_drive & port_cfg.gpio_out);
   assign pads_d.oe = drv_req & ~(port_cfg.opendrain_control & drv_val);
   assign pads_d.out = drv_val & ~port_cfg.opendrain_control;
   assign pads_d.pu = port_cfg.pullup_control & (~drv_req | port_cfg.opendrain_control);

   // ==========================================================
   // Input routing
   logic [1:0] rx_ok_a, rx_ok_b;
   logic rx2_ok;
   periph_in_t pin_d;

   assign rx_ok_a[0] = periph_cfg.uart_rx_en[0] && !periph_cfg.uart_rx_sel_b[0]
                       && !dir[UART0_RX_PIN_A];
   assign rx_ok_b[0] = periph_cfg.uart_rx_en[0] && periph_cfg.uart_rx_sel_b[0]
                       && !dir[UART0_RX_PIN_B];
   assign rx_ok_a[1] = periph_cfg.uart_rx_en[1] && !periph_cfg.uart_rx_sel_b[1]
                       && !dir[UART1_RX_PIN_A];
   assign rx_ok_b[1] = periph_cfg.uart_rx_en[1] && periph_cfg.uart_rx_sel_b[1]
                       && !dir[UART1_RX_PIN_B];
   assign rx2_ok = periph_cfg.uart_rx_en[2] && !dir[UART2_RX_PIN_A];

   // An unrouted receive line idles high so no false start bit is seen.
   assign pin_d.uart_rx[0] = rx_ok_a[0] ? stable_q[UART0_RX_PIN_A]
                             : (rx_ok_b[0] ? stable_q[UART0_RX_PIN_B] : 1'b1);
   assign pin_d.uart_rx[1] = rx_ok_a[1] ? stable_q[UART1_RX_PIN_A]
                             : (rx_ok_b[1] ? stable_q[UART1_RX_PIN_B] : 1'b1);
   assign pin_d.uart_rx[2] = rx2_ok ? stable_q[UART2_RX_PIN_A] : 1'b1;
   assign pin_d.twowire_data_in = periph_cfg.twowire_sel_b ? stable_q[TWOWIRE_DATA_PIN_B]
                                  : stable_q[TWOWIRE_DATA_PIN_A];
   assign pin_d.twowire_clock_in = periph_cfg.twowire_sel_b ? stable_q[TWOWIRE_CLOCK_PIN_B]
                                   : stable_q[TWOWIRE_CLOCK_PIN_A];
   assign pin_d.programmer_data_in = stable_q[PROGRAMMER_DATA_PIN];
   assign pin_d.programmer_clock_in = periph_cfg.programmer_en
                                      && stable_q[PROGRAMMER_CLOCK_PIN];
   assign pin_d.timer_event = ev_q_d;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pads_q <= '0;
         periph_in_q <= '0;
         gpio_in_q <= PIN_RESET;
      end else begin
         pads_q <= pads_d;
         periph_in_q <= pin_d;
         gpio_in_q <= stable_q;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence s_buzz_running;
      periph_cfg.buzz_en ##1 periph_cfg.buzz_en;
   endsequence

   a_uart0_rx_route: assert property (
      rx_ok_a[0] |=> periph_in_q.uart_rx[0] == $past(stable_q[UART0_RX_PIN_A]))
      else $error("uart0 receive not taken from pin a");

   a_uart_rx_idle: assert property (
      (!rx_ok_a[1] && !rx_ok_b[1]) |=> periph_in_q.uart_rx[1])
      else $error("unrouted uart1 receive not idle high");

   a_twowire_open_drain: assert property (
      (tw_data_a && !periph_out.twowire_data_out)
      |=> pads_q.oe[TWOWIRE_DATA_PIN_A] && !pads_q.out[TWOWIRE_DATA_PIN_A])
      else $error("two-wire data not pulled low");

   a_twowire_release: assert property (
      (tw_data_a && periph_out.twowire_data_out) |=> !pads_q.oe[TWOWIRE_DATA_PIN_A])
      else $error("two-wire data not released");

   a_twowire_clock_sense: assert property (
      (!periph_cfg.twowire_sel_b && $stable(periph_cfg.twowire_sel_b))
      |-> periph_in_q.twowire_clock_in == $past(stable_q[TWOWIRE_CLOCK_PIN_A]))
      else $error("two-wire clock input not followed");

   a_timer_output: assert property (
      fn_drive[TIMER0_IO_PIN_A] |=> pads_q.oe[TIMER0_IO_PIN_A] ||
      $past(port_cfg.opendrain_control[TIMER0_IO_PIN_A] && periph_out.timer_out[0]))
      else $error("timer output not driven");

   a_timer_event: assert property (
      (periph_cfg.timer_ev_route[0] == 1'b0) |=> !periph_in_q.timer_event[0])
      else $error("unrouted timer event seen");

   a_buzz_gate: assert property (
      (!periph_cfg.buzz_en && omd[BUZZER_DRIVE_PIN] && dir[BUZZER_DRIVE_PIN])
      |=> pads_q.out[BUZZER_DRIVE_PIN] == $past(port_cfg.gpio_out[BUZZER_DRIVE_PIN]
          && !port_cfg.opendrain_control[BUZZER_DRIVE_PIN]))
      else $error("buzzer pin driven while off");

   a_buzz_diff: assert property (
      (fn_drive[BUZZER_DRIVE_PIN] && fn_drive[BUZZER_DRIVE_INVERTED_PIN]
       && port_cfg.opendrain_control[BUZZER_DRIVE_INVERTED_PIN:BUZZER_DRIVE_PIN] == 2'h0)
      |=> pads_q.out[BUZZER_DRIVE_PIN] != pads_q.out[BUZZER_DRIVE_INVERTED_PIN])
      else $error("buzzer pair not complementary");

   a_buzz_toggle: assert property (
      s_buzz_running ##0 buzz_tick |=> buzz_q != $past(buzz_q))
      else $error("buzzer did not toggle on tick");

   a_gpio_fallback: assert property (
      (fn_drive[UART0_RX_PIN_A] == 1'b0 && dir[UART0_RX_PIN_A]
       && !port_cfg.opendrain_control[UART0_RX_PIN_A])
      |=> pads_q.oe[UART0_RX_PIN_A]
          && pads_q.out[UART0_RX_PIN_A] == $past(port_cfg.gpio_out[UART0_RX_PIN_A]))
      else $error("gpio fallback not driven");

   a_prog_clock_input: assert property (
      periph_cfg.programmer_en |=> !pads_q.oe[PROGRAMMER_CLOCK_PIN])
      else $error("programmer clock pin driven");

   a_input_hiz: assert property (
      (dir == PIN_RESET && port_cfg.pullup_control == PIN_RESET && !periph_cfg.programmer_en)
      |=> pads_q.oe == PIN_RESET && pads_q.pu == PIN_RESET)
      else $error("input pins not high impedance");

   a_uart0_rx_pin_b: assert property (
      rx_ok_b[0] |=> periph_in_q.uart_rx[0] == $past(stable_q[UART0_RX_PIN_B]))
      else $error("uart0 receive not taken from pin b");

   a_uart2_rx_route: assert property (
      rx2_ok |=> periph_in_q.uart_rx[2] == $past(stable_q[UART2_RX_PIN_A]))
      else $error("uart2 receive not taken from its pin");

   a_uart2_rx_idle: assert property (
      !rx2_ok |=> periph_in_q.uart_rx[2])
      else $error("unrouted uart2 receive not idle high");

   a_twowire_data_sense: assert property (
      (!periph_cfg.twowire_sel_b && $stable(periph_cfg.twowire_sel_b))
      |-> periph_in_q.twowire_data_in == $past(stable_q[TWOWIRE_DATA_PIN_A]))
      else $error("two-wire data input not followed");

   a_twowire_clock_drive: assert property (
      (tw_clock_b && !periph_out.twowire_clock_out)
      |=> pads_q.oe[TWOWIRE_CLOCK_PIN_B] && !pads_q.out[TWOWIRE_CLOCK_PIN_B])
      else $error("two-wire clock not pulled low");

   a_prog_data_drive: assert property (
      (periph_cfg.programmer_en && periph_out.programmer_data_oe
       && !port_cfg.opendrain_control[PROGRAMMER_DATA_PIN])
      |=> pads_q.oe[PROGRAMMER_DATA_PIN]
          && pads_q.out[PROGRAMMER_DATA_PIN] == $past(periph_out.programmer_data_out))
      else $error("programmer data not driven");

   a_prog_clock_gate: assert property (
      !periph_cfg.programmer_en |=> !periph_in_q.programmer_clock_in)
      else $error("programmer clock seen while unused");

   a_timer_event_b: assert property (
      (periph_cfg.timer_ev_route[0] && periph_cfg.timer_ev_sel_b[0]
       && !dir[TIMER0_IO_PIN_A + 1])
      |=> periph_in_q.timer_event[0] == $past(stable_q[TIMER0_IO_PIN_A + 1]))
      else $error("timer event not taken from pin b");

   a_timer_event_dir: assert property (
      (dir[TIMER0_IO_PIN_A] && dir[TIMER0_IO_PIN_A + 1]) |=> !periph_in_q.timer_event[0])
      else $error("timer event seen on output pins");

   a_timer_pullup: assert property (
      (!dir[TIMER0_IO_PIN_A] && port_cfg.pullup_control[TIMER0_IO_PIN_A])
      |=> pads_q.pu[TIMER0_IO_PIN_A])
      else $error("timer input pull-up missing");

   a_timer_drive_b: assert property (
      (fn_drive[TIMER0_IO_PIN_A + 2 * N_TIMERS - 1]
       && !port_cfg.opendrain_control[TIMER0_IO_PIN_A + 2 * N_TIMERS - 1])
      |=> pads_q.oe[TIMER0_IO_PIN_A + 2 * N_TIMERS - 1]
          && pads_q.out[TIMER0_IO_PIN_A + 2 * N_TIMERS - 1] == $past(periph_out.timer_out[4]))
      else $error("timer 4 output not driven");

   a_buzz_quiet: assert property (
      !periph_cfg.buzz_en |=> !buzz_q && buzz_cnt_q == BUZZ_CNT_RESET)
      else $error("buzzer divider running while off");

   a_gpio_input: assert property (
      1'b1 |=> gpio_in_q == $past(stable_q))
      else $error("gpio input not following filter");

endmodule // peripheral_pin_function_select

// [pin_mux_pkg.sv]
// Constants, pin indices and carrier types for the shared pin function multiplexer.
// Assumes one 50 MHz clock and that the port and serial mode registers live elsewhere.

package pin_mux_pkg;

   // ==========================================================
   // Pin indices
   localparam int N_PINS = 23;
   localparam int UART0_RX_PIN_A = 0;
   localparam int UART0_RX_PIN_B = 1;
   localparam int UART1_RX_PIN_A = 2;
   localparam int UART1_RX_PIN_B = 3;
   localparam int UART2_RX_PIN_A = 4;
   localparam int TWOWIRE_DATA_PIN_A = 5;
   localparam int TWOWIRE_DATA_PIN_B = 6;
   localparam int TWOWIRE_CLOCK_PIN_A = 7;
   localparam int TWOWIRE_CLOCK_PIN_B = 8;
   localparam int PROGRAMMER_DATA_PIN = 9;
   localparam int PROGRAMMER_CLOCK_PIN = 10;
   localparam int TIMER0_IO_PIN_A = 11;
   localparam int N_TIMERS = 5;
   localparam int BUZZER_DRIVE_PIN = 21;
   localparam int BUZZER_DRIVE_INVERTED_PIN = 22;

   // ==========================================================
   // Reset values and timing
   localparam logic [N_PINS-1:0] PIN_RESET = 23'h000000;
   localparam logic [15:0] BUZZ_CNT_RESET = 16'h0000;
   localparam logic [15:0] BUZZ_DIV_BASE = 16'h7fff;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [N_PINS-1:0] port_direction;
      logic [N_PINS-1:0] output_function_select;
      logic [N_PINS-1:0] opendrain_control;
      logic [N_PINS-1:0] pullup_control;
      logic [N_PINS-1:0] gpio_out;
   } port_cfg_t;

   typedef struct packed {
      logic [2:0] uart_rx_en;
      logic [1:0] uart_rx_sel_b;
      logic twowire_en;
      logic twowire_sel_b;
      logic programmer_en;
      logic [4:0] timer_ev_route;
      logic [4:0] timer_ev_sel_b;
      logic buzz_en;
      logic [2:0] buzz_freq_sel;
   } periph_cfg_t;

   typedef struct packed {
      logic twowire_data_out;
      logic twowire_clock_out;
      logic programmer_data_out;
      logic programmer_data_oe;
      logic [4:0] timer_out;
   } periph_out_t;

   typedef struct packed {
      logic [2:0] uart_rx;
      logic twowire_data_in;
      logic twowire_clock_in;
      logic programmer_data_in;
      logic programmer_clock_in;
      logic [4:0] timer_event;
   } periph_in_t;

   typedef struct packed {
      logic [N_PINS-1:0] out;
      logic [N_PINS-1:0] oe;
      logic [N_PINS-1:0] pu;
   } pad_drive_t;

endpackage

// [pin_partner.sv]
// Far-side model of the shared pins: external parties, bus pull-ups and floating pins.
// Assumes the pad drive of the block and one clock that paces the floating pattern.
`timescale 1ns/1ns
module pin_partner import pin_mux_pkg::*; (
   // Clock
   input wire logic clk,
   // Drive from the block
   input pad_drive_t pads,
   // External parties
   input wire logic [N_PINS-1:0] ext_en,
   input wire logic [N_PINS-1:0] ext_val,
   // Resolved pin levels
   output logic [N_PINS-1:0] pad_level
);
   // ==========================================================
   // Level resolution
   logic flt_q = 1'b0;
   always @(posedge clk) begin
      flt_q <= ~flt_q;
   end
   // A driven pin wins; two drivers form a wired AND; a floating pin without pull-up toggles.
   always_comb begin
      for (int i = 0; i < N_PINS; i++) begin
         if (pads.oe[i] && ext_en[i])
            pad_level[i] = pads.out[i] & ext_val[i];
         else if (pads.oe[i])
            pad_level[i] = pads.out[i];
         else if (ext_en[i])
            pad_level[i] = ext_val[i];
         else
            pad_level[i] = pads.pu[i] | flt_q;
      end
   end
endmodule // pin_partner

// [testbench.sv]
// Self-checking testbench of the shared pin function multiplexer.
// Assumes pin_partner resolves the pins and the package pin map.
`timescale 1ns/1ns
module testbench;
   import pin_mux_pkg::*;
   // ==========================================================
   // Signals
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   port_cfg_t pc;
   periph_cfg_t pf;
   periph_out_t po;
   pad_drive_t pads_q;
   periph_in_t pin_q;
   logic [N_PINS-1:0] gpio_in_q, pad_in, ext_en, ext_val;
   int num_errors = 0;
   int n_compared = 0;
   always #10 clk = ~clk;
   peripheral_pin_function_select dut (.clk(clk), .arst_n(arst_n), .pad_in(pad_in),
      .pads_q(pads_q), .port_cfg(pc), .periph_cfg(pf), .periph_out(po),
      .periph_in_q(pin_q), .gpio_in_q(gpio_in_q));
   pin_partner far (.clk(clk), .pads(pads_q), .ext_en(ext_en), .ext_val(ext_val),
      .pad_level(pad_in));
   // ==========================================================
   // Helpers
   task automatic check(input logic [3*N_PINS-1:0] seen, input logic [3*N_PINS-1:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic clear();
      pc = '0;
      pf = '0;
      po = '0;
      ext_en = '0;
      ext_val = '0;
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      clear();
      pc.port_direction = '1;
      pc.gpio_out = '1;
      pc.pullup_control = '1;
      step(3);
      arst_n = 1'b0;
      #1;
      check(pads_q, '0);
      step(4);
      check(pads_q, '0);
      clear();
      arst_n = 1'b1;
      step(2);
      check({pads_q.oe, pads_q.pu}, '0);
      $display("test reset done");
   endtask
   task automatic t_gpio();
      clear();
      pc.port_direction[0] = 1'b1;
      pc.gpio_out[0] = 1'b1;
      step(2);
      check({pads_q.oe[0], pads_q.out[0], pads_q.pu[0]}, 3'h6);
      pc.opendrain_control[0] = 1'b1;
      pc.pullup_control[0] = 1'b1;
      step(2);
      check({pads_q.oe[0], pads_q.out[0], pads_q.pu[0]}, 3'h1);
      pc.port_direction[3] = 1'b0;
      ext_en[3] = 1'b1;
      ext_val[3] = 1'b1;
      step(8);
      check(gpio_in_q[3], 1'b1);
      ext_val[3] = 1'b0;
      step(8);
      check(gpio_in_q[3], 1'b0);
      $display("test gpio done");
   endtask
   task automatic t_uart();
      int pin [5] = '{0, 1, 2, 3, 4};
      int u [5] = '{0, 0, 1, 1, 2};
      for (int k = 0; k < 5; k++) begin
         clear();
         pf.uart_rx_en[u[k]] = 1'b1;
         if (u[k] < 2) pf.uart_rx_sel_b[u[k]] = k[0];
         ext_en[pin[k]] = 1'b1;
         step(8);
         check(pin_q.uart_rx[u[k]], 1'b0);
         ext_val[pin[k]] = 1'b1;
         step(8);
         check(pin_q.uart_rx[u[k]], 1'b1);
         ext_val[pin[k]] = 1'b0;
         pc.port_direction[pin[k]] = 1'b1;
         step(8);
         check(pin_q.uart_rx[u[k]], 1'b1);
         pc.port_direction[pin[k]] = 1'b0;
         pf.uart_rx_en[u[k]] = 1'b0;
         step(8);
         check(pin_q.uart_rx[u[k]], 1'b1);
      end
      $display("test uart done");
   endtask
   task automatic t_twowire();
      int dp, cp;
      for (int s = 0; s < 2; s++) begin
         clear();
         dp = TWOWIRE_DATA_PIN_A + s;
         cp = TWOWIRE_CLOCK_PIN_A + s;
         pf.twowire_en = 1'b1;
         pf.twowire_sel_b = s[0];
         pc.port_direction[dp] = 1'b1;
         pc.port_direction[cp] = 1'b1;
         pc.opendrain_control[dp] = 1'b1;
         pc.opendrain_control[cp] = 1'b1;
         pc.pullup_control[cp] = 1'b1;
         po.twowire_clock_out = 1'b1;
         step(2);
         check({pads_q.oe[dp], pads_q.out[dp]}, 2'h2);
         check({pads_q.oe[cp], pads_q.pu[cp]}, 2'h1);
         ext_en[cp] = 1'b1;
         po.twowire_data_out = 1'b1;
         ext_en[dp] = 1'b1;
         step(8);
         check({pin_q.twowire_clock_in, pin_q.twowire_data_in}, 2'h0);
         check(pads_q.oe[dp], 1'b0);
         po.twowire_clock_out = 1'b0;
         ext_en[cp] = 1'b0;
         step(2);
         check({pads_q.oe[cp], pads_q.out[cp]}, 2'h2);
      end
      $display("test twowire done");
   endtask
   task automatic t_timer();
      int p;
      for (int i = 0; i < N_TIMERS; i++) begin
         for (int j = 0; j < 2; j++) begin
            clear();
            p = TIMER0_IO_PIN_A + 2 * i + j;
            pc.port_direction[p] = 1'b1;
            pc.output_function_select[p] = 1'b1;
            po.timer_out[i] = 1'b1;
            step(2);
            check({pads_q.oe[p], pads_q.out[p]}, 2'h3);
            pc.output_function_select[p] = 1'b0;
            step(2);
            check({pads_q.oe[p], pads_q.out[p]}, 2'h2);
            pc.port_direction[p] = 1'b0;
            pc.pullup_control[p] = 1'b1;
            pf.timer_ev_route[i] = 1'b1;
            pf.timer_ev_sel_b[i] = j[0];
            ext_en[p] = 1'b1;
            ext_val[p] = 1'b1;
            step(8);
            check({pads_q.pu[p], pin_q.timer_event[i]}, 2'h3);
            ext_val[p] = 1'b0;
            step(8);
            check(pin_q.timer_event[i], 1'b0);
         end
      end
      $display("test timer done");
   endtask
   task automatic t_buzzer();
      logic b;
      int n;
      for (int s = 7; s > 5; s--) begin
         clear();
         pc.port_direction[BUZZER_DRIVE_PIN] = 1'b1;
         pc.port_direction[BUZZER_DRIVE_INVERTED_PIN] = 1'b1;
         pc.output_function_select[BUZZER_DRIVE_PIN] = 1'b1;
         pc.output_function_select[BUZZER_DRIVE_INVERTED_PIN] = 1'b1;
         pf.buzz_en = 1'b1;
         pf.buzz_freq_sel = s[2:0];
         step(3);
         b = pads_q.out[BUZZER_DRIVE_PIN];
         check(pads_q.oe[BUZZER_DRIVE_INVERTED_PIN:BUZZER_DRIVE_PIN], 2'h3);
         check(pads_q.out[BUZZER_DRIVE_INVERTED_PIN], !b);
         n = 0;
         while (pads_q.out[BUZZER_DRIVE_PIN] === b && n < 1200) begin
            step(1);
            n++;
         end
         b = pads_q.out[BUZZER_DRIVE_PIN];
         n = 0;
         while (pads_q.out[BUZZER_DRIVE_PIN] === b && n < 1200) begin
            step(1);
            n++;
         end
         check(n, 32'h100 << (7 - s));
         check(pads_q.out[BUZZER_DRIVE_INVERTED_PIN], !pads_q.out[BUZZER_DRIVE_PIN]);
      end
      pc.output_function_select = '0;
      pc.gpio_out[BUZZER_DRIVE_PIN] = 1'b1;
      step(600);
      check(pads_q.out[BUZZER_DRIVE_INVERTED_PIN:BUZZER_DRIVE_PIN], 2'h1);
      pc.output_function_select = '1;
      pf.buzz_en = 1'b0;
      step(2);
      check(pads_q.out[BUZZER_DRIVE_INVERTED_PIN:BUZZER_DRIVE_PIN], 2'h1);
      $display("test buzzer done");
   endtask
   task automatic t_prog();
      clear();
      pf.programmer_en = 1'b1;
      pc.port_direction[PROGRAMMER_DATA_PIN] = 1'b1;
      pc.port_direction[PROGRAMMER_CLOCK_PIN] = 1'b1;
      po.programmer_data_oe = 1'b1;
      po.programmer_data_out = 1'b1;
      step(2);
      check({pads_q.oe[PROGRAMMER_DATA_PIN], pads_q.out[PROGRAMMER_DATA_PIN]}, 2'h3);
      check(pads_q.oe[PROGRAMMER_CLOCK_PIN], 1'b0);
      po.programmer_data_oe = 1'b0;
      ext_en[PROGRAMMER_DATA_PIN] = 1'b1;
      ext_en[PROGRAMMER_CLOCK_PIN] = 1'b1;
      ext_val[PROGRAMMER_CLOCK_PIN] = 1'b1;
      step(8);
      check({pin_q.programmer_data_in, pin_q.programmer_clock_in}, 2'h1);
      $display("test programmer done");
   endtask
   // ==========================================================
   // Sequence and watchdog
   initial begin
      clear();
      step(4);
      arst_n = 1'b1;
      step(2);
      t_gpio();
      t_uart();
      t_twowire();
      t_timer();
      t_buzzer();
      t_prog();
      t_reset();
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end
endmodule // testbench
